/* hw/mswp_player.sv */
// multisegment waveform player: segment table, playback address, guards
// assumes sample memory outside reads at addr_o; one clock at 40 MHz
`timescale 1ns/1ps
`include "mswp_defs.svh"
module mswp_player
   import mswp_pkg::*;
#(
   parameter int AW = 25,
   parameter logic [24:0] MEM_SIZE = `MSWP_MEM_SMALL
)
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic enable_i,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic write_i,
   input wire logic read_i,
   output logic [31:0] rdata_o,
   input wire logic [31:0] mem_sample_i,
   input wire logic ext_clock_pin_i,
   output logic [AW-1:0] mem_addr_o,
   output logic [31:0] sample_o,
   output logic [3:0] marker_o,
   output logic sample_valid_o,
   output logic sample_clock_o,
   output logic [1:0] clock_source_o,
   output logic [7:0] segment_rate_o
);

   localparam int LAT_CYC = (`MSWP_LAT_NS + `MSWP_CLK_NS - 1) / `MSWP_CLK_NS;

   // segment table storage, flip-flops indexed by segment number
   logic [AW-1:0] seg_base_r [0:29];
   logic [AW-1:0] seg_len_r [0:29];
   logic [3:0] seg_mark_r [0:29];
   logic [7:0] seg_rate_r [0:29];
   logic [AW-1:0] base_nxt, len_nxt;
   logic [3:0] mark_nxt;
   logic [7:0] rate_nxt;
   logic tbl_we;

   logic [5:0] nseg_r, nseg_nxt;
   logic [AW-1:0] total_r, total_nxt;
   logic [4:0] cur_r, cur_nxt, pend_r, pend_nxt;
   logic pend_v_r, pend_v_nxt;
   mswp_state_t st_r, st_nxt;
   mswp_trig_mode_t trig_r, trig_nxt;
   mswp_clk_src_t src_r, src_nxt;
   logic [4:0] resol_r, resol_nxt;
   logic [7:0] rate_r, rate_nxt2, mdly_r, mdly_nxt;
   logic [3:0] mlist_r, mlist_nxt;
   logic [AW-1:0] pos_r, pos_nxt;
   logic [3:0] rej_r, rej_nxt;
   logic [31:0] rdata_nxt;
   logic [3:0] reg_mark_r, reg_mark_nxt;
   logic [AW-1:0] seg_len_arg;
   logic [7:0] div_r, div_nxt;
   logic sclk_r, sclk_nxt;
   logic ext_s1_r, ext_s2_r, ext_s3_r;
   logic [31:0] samp_r;
   logic [3:0] mk_r;
   logic [LAT_CYC-1:0] vpipe_r;
   logic playing, ext_tick, tick_play;
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);

   // rounds a requested length up to a repetition meeting minimum and x4, or to all ones where x4 would overflow
   function automatic logic [AW-1:0] mswp_seg_len(input logic [AW-1:0] src);
      logic [AW-1:0] l;
      l = (src == '0) ? AW'(4) : src;
      for (int k = 0; k < AW; k++)
         if (l < AW'(`MSWP_MIN_SEG_LEN)) l = AW'(l << 1); // R7 R2
      if (l[1:0] != 2'h0)
         l = (l[AW-1:AW-2] != 2'h0) ? '1 : AW'(l << 2); // R3 R7
      return l;
   endfunction : mswp_seg_len

   assign playing = (st_r == MSWP_PLAY);
   assign seg_len_arg = AW'(wdata_i);

   // register writes, segment building and command guards
   always_comb
   begin
      nseg_nxt = nseg_r;
      total_nxt = total_r;
      cur_nxt = cur_r;
      pend_nxt = pend_r;
      pend_v_nxt = pend_v_r;
      st_nxt = st_r;
      trig_nxt = trig_r;
      src_nxt = src_r;
      resol_nxt = resol_r;
      rate_nxt2 = rate_r;
      mdly_nxt = mdly_r;
      mlist_nxt = mlist_r;
      rej_nxt = rej_r;
      reg_mark_nxt = reg_mark_r;
      tbl_we = 1'b0;
      len_nxt = mswp_seg_len(seg_len_arg);
      base_nxt = total_r;
      mark_nxt = reg_mark_r;
      rate_nxt = rate_r;
      if (pend_v_r && playing)
      begin
         cur_nxt = pend_r; // R22 R6
         pend_v_nxt = 1'b0;
      end
      if (write_i)
      begin
         if (addr_i == `MSWP_REG_CTRL)
         begin
            if (wdata_i[`MSWP_CTRL_ARM] && nseg_r != 6'h00 &&
                trig_r != MSWP_TRIG_GATED) // R9
               st_nxt = MSWP_ARMED;
            if (wdata_i[`MSWP_CTRL_TRIG] && st_r == MSWP_ARMED)
               st_nxt = MSWP_PLAY;
            if (wdata_i[`MSWP_CTRL_STOP])
               st_nxt = MSWP_IDLE;
            if (wdata_i[`MSWP_CTRL_CLEAR] && !playing)
            begin
               nseg_nxt = 6'h00;
               total_nxt = '0;
               cur_nxt = 5'h00;
               rej_nxt = 4'h0;
               pend_v_nxt = 1'b0;
            end
         end
         else if (addr_i == `MSWP_REG_SEGSEL)
         begin
            // index change only, memory untouched
            if (wdata_i[5:0] < nseg_r) // R21
            begin
               pend_nxt = wdata_i[4:0]; // R6
               pend_v_nxt = 1'b1;
            end
         end
         else if (addr_i == `MSWP_REG_SEGCFG)
         begin
            reg_mark_nxt = wdata_i[3:0]; // R5
         end
         else if (addr_i == `MSWP_REG_SEGADD)
         begin
            // append a segment, refused beyond count or memory size
            if (playing || nseg_r >= `MSWP_MAX_SEGS) // R1
               rej_nxt[0] = 1'b1; // R14
            else if ({1'b0, total_r} + {1'b0, len_nxt} >
                     {1'b0, MEM_SIZE[AW-1:0]}) // R4
               rej_nxt[0] = 1'b1;
            else
            begin
               tbl_we = 1'b1; // R5
               nseg_nxt = 6'(nseg_r + 6'h01);
               total_nxt = AW'(total_r + len_nxt);
            end
         end
         else if (addr_i == `MSWP_REG_TRIGMODE)
         begin
            if (st_r != MSWP_IDLE && wdata_i[1:0] == MSWP_TRIG_GATED) // R9
               rej_nxt[1] = 1'b1; // R14
            else if (wdata_i[1:0] != 2'h3)
               trig_nxt = mswp_trig_mode_t'(wdata_i[1:0]);
         end
         else if (addr_i == `MSWP_REG_MARKDLY)
         begin
            if (playing) rej_nxt[2] = 1'b1; // R11 R14
            else mdly_nxt = wdata_i[7:0];
         end
         else if (addr_i == `MSWP_REG_MARKLIST)
         begin
            if (playing) rej_nxt[2] = 1'b1; // R10 R14
            else mlist_nxt = wdata_i[3:0];
         end
         else if (addr_i == `MSWP_REG_RESOL)
         begin
            if (playing) rej_nxt[3] = 1'b1; // R12 R14
            else if (wdata_i[4:0] >= `MSWP_RESOL_MIN &&
                     wdata_i[4:0] <= `MSWP_RESOL_RESET)
               resol_nxt = wdata_i[4:0];
         end
         else if (addr_i == `MSWP_REG_CLKRATE)
         begin
            if (playing) rej_nxt[3] = 1'b1; // R13 R14
            else rate_nxt2 = wdata_i[7:0];
         end
         else if (addr_i == `MSWP_REG_CLKSRC)
         begin
            if (wdata_i[1:0] != 2'h3)
               src_nxt = mswp_clk_src_t'(wdata_i[1:0]); // R16
         end
      end
   end

   // playback address walk and deferred segment switch
   always_comb
   begin
      pos_nxt = pos_r;
      if (st_nxt != MSWP_PLAY)
         pos_nxt = '0;
      else if (pend_v_r && playing) // R22
         pos_nxt = '0;
      else if (ext_tick)
         pos_nxt = (pos_r + AW'(1) >= seg_len_r[cur_r]) ? '0 :
            AW'(pos_r + AW'(1));
   end

   // sample tick: internal divider or synchronised pin rising edge
   assign ext_tick = (src_r == MSWP_CLK_INT) ? (div_r == 8'h00) :
      (ext_s2_r && !ext_s3_r); // R15 R16
   assign tick_play = ext_tick && playing;
   // divider reloads from the playing segment's own clock rate
   always_comb
   begin
      div_nxt = 8'(div_r - 8'h01);
      if (!playing || div_r == 8'h00)
         div_nxt = seg_rate_r[cur_r]; // R5
      sclk_nxt = tick_play; // R17
   end
   // read data, standing only in the cycle after the read strobe
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      if (read_i)
      begin
         if (addr_i == `MSWP_REG_SEGSEL) rdata_nxt = 32'(cur_r);
         else if (addr_i == `MSWP_REG_TRIGMODE) rdata_nxt = 32'(trig_r);
         else if (addr_i == `MSWP_REG_MARKDLY) rdata_nxt = 32'(mdly_r);
         else if (addr_i == `MSWP_REG_MARKLIST) rdata_nxt = 32'(mlist_r);
         else if (addr_i == `MSWP_REG_RESOL) rdata_nxt = 32'(resol_r);
         else if (addr_i == `MSWP_REG_CLKRATE) rdata_nxt = 32'(rate_r);
         else if (addr_i == `MSWP_REG_STATUS)
            rdata_nxt = 32'({rej_r, nseg_r});
      end
   end
   // state registers, all frozen while the clock enable is low
   always_ff @(posedge clock_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int i = 0; i < `MSWP_MAX_SEGS; i++)
         begin
            seg_base_r[i] <= '0;
            seg_len_r[i] <= '0;
            seg_mark_r[i] <= 4'h0;
            seg_rate_r[i] <= 8'h00;
         end
         nseg_r <= 6'h00;
         total_r <= '0;
         cur_r <= 5'h00;
         pend_r <= 5'h00;
         pend_v_r <= 1'b0;
         st_r <= MSWP_IDLE;
         trig_r <= MSWP_TRIG_AUTO;
         src_r <= MSWP_CLK_INT;
         resol_r <= `MSWP_RESOL_RESET;
         rate_r <= 8'h00;
         mdly_r <= 8'h00;
         mlist_r <= 4'h0;
         pos_r <= '0;
         rej_r <= 4'h0;
         reg_mark_r <= 4'h0;
         div_r <= 8'h00;
         sclk_r <= 1'b0;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
         samp_r <= 32'h0000_0000;
         mk_r <= 4'h0;
         vpipe_r <= '0;
         rdata_o <= 32'h0000_0000;
      end
      else if (enable_i)
      begin
         nseg_r <= nseg_nxt;
         total_r <= total_nxt;
         cur_r <= cur_nxt;
         pend_r <= pend_nxt;
         pend_v_r <= pend_v_nxt;
         st_r <= st_nxt;
         trig_r <= trig_nxt;
         src_r <= src_nxt;
         resol_r <= resol_nxt;
         rate_r <= rate_nxt2;
         mdly_r <= mdly_nxt;
         mlist_r <= mlist_nxt;
         pos_r <= pos_nxt;
         rej_r <= rej_nxt;
         reg_mark_r <= reg_mark_nxt;
         div_r <= div_nxt;
         sclk_r <= sclk_nxt;
         ext_s1_r <= ext_clock_pin_i;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
         samp_r <= tick_play ? mem_sample_i : samp_r;
         mk_r <= tick_play ? seg_mark_r[cur_r] : mk_r; // R10
         vpipe_r <= LAT_CYC'({vpipe_r, tick_play}); // R20
         rdata_o <= rdata_nxt;
         if (tbl_we)
         begin
            seg_base_r[nseg_r[4:0]] <= base_nxt;
            seg_len_r[nseg_r[4:0]] <= len_nxt; // R2 R3
            seg_mark_r[nseg_r[4:0]] <= mark_nxt; // R5
            seg_rate_r[nseg_r[4:0]] <= rate_nxt; // R5
         end
      end
   end
   // outputs from registers and the playing segment's table entries; mem_addr_o adds pos_r to the segment base
   assign mem_addr_o = AW'(seg_base_r[cur_r] + pos_r); // R6
   assign sample_o = samp_r;
   assign marker_o = mk_r; // R10
   assign sample_valid_o = vpipe_r[LAT_CYC-1]; // R20
   assign sample_clock_o = sclk_r; // R17
   assign clock_source_o = src_r; // R16
   assign segment_rate_o = seg_rate_r[cur_r]; // R5
   // a pending index restarts the walk at sample zero
   sequence pend_at_play_s;
      playing && pend_v_r && enable_i;
   endsequence
   sequence walk_restart_s;
      pos_r == '0 && cur_r == $past(pend_r);
   endsequence
   seg_switch_a: assert property (pend_at_play_s |=> walk_restart_s) // R22 R6
      else $error("segment switch did not restart at sample zero");
   seg_shape_a: assert property (tbl_we |-> len_nxt[1:0] == 2'h0 && // R2 R3
      len_nxt >= AW'(`MSWP_MIN_SEG_LEN))
      else $error("stored segment length breaks the length rules");
   mem_fit_a: assert property (total_r <= MEM_SIZE[AW-1:0]) // R4
      else $error("segments exceed output memory");
   gated_off_a: assert property (playing |-> trig_r != MSWP_TRIG_GATED) // R9
      else $error("gated trigger active during output");
   index_range_a: assert property (nseg_r != 6'h00 |-> // R21
      6'(cur_r) < nseg_r) else $error("index beyond stored segments");
   resol_lock_a: assert property (playing && enable_i && write_i && // R12 R14
      addr_i == `MSWP_REG_RESOL |=> $stable(resol_r))
      else $error("resolution changed during output");
endmodule : mswp_player

/* hw/mswp_defs.svh */
// constants of the multisegment waveform player: offsets, fields, limits
// assumes inclusion by the package, the player and its bench
//
// Function
// R1: at most thirty segments; adding a thirty-first is refused.
// R2: each stored segment holds at least 131072 samples.
// R3: each segment length in samples is a multiple of four.
// R4: total length fits output memory, 4 or 16 Msamples by model.
// R5: each segment keeps its own marker assignment and clock rate.
// R6: writing a new segment index switches playback without reloading memory.
// R7: short or odd segments are built by repeating the source waveform.
// R8: host should give all segments one clock rate for fast changes.
// R9: gated trigger mode is rejected during multisegment output.
// R10: marker lists given after loading are not applied during output.
// R11: marker sample delay requests are rejected during multisegment output.
// R12: output resolution change requests are rejected during output.
// R13: new clock frequency settings are rejected during output.
// R14: an incompatible request is ignored, leaving all settings unchanged.
// R15: external sample clock accepted; output then follows that clock.
// R16: clock source select: internal, external low range, external high.
// R17: system clock mode outputs clock and data synchronous, up to 100 MHz.
// R18: direct external clock to the target stays at or below 40 MHz.
// R19: between 40 and 100 MHz the outside party equalises clock delay.
// R20: output data appears 20 to 25 ns after the input clock edge.
// R21: out of range segment index is ignored; playback continues.
// R22: segment change acts only when armed and triggered, from first sample.
`ifndef MSWP_DEFS_SVH
`define MSWP_DEFS_SVH

// register indices (byte address is index times four)
`define MSWP_REG_CTRL      4'h0
`define MSWP_REG_SEGSEL    4'h1
`define MSWP_REG_SEGADD    4'h2
`define MSWP_REG_SEGCFG    4'h3
`define MSWP_REG_TRIGMODE  4'h4
`define MSWP_REG_MARKDLY   4'h5
`define MSWP_REG_RESOL     4'h6
`define MSWP_REG_CLKRATE   4'h7
`define MSWP_REG_CLKSRC    4'h8
`define MSWP_REG_STATUS    4'h9
`define MSWP_REG_MARKLIST  4'ha

// control fields
`define MSWP_CTRL_ARM      0
`define MSWP_CTRL_TRIG     1
`define MSWP_CTRL_STOP     2
`define MSWP_CTRL_CLEAR    3

// limits
`define MSWP_MAX_SEGS      6'h1e
`define MSWP_MIN_SEG_LEN   25'h0020000
`define MSWP_MEM_SMALL     25'h0400000
`define MSWP_MEM_LARGE     25'h1000000
`define MSWP_RESOL_RESET   5'h10
`define MSWP_RESOL_MIN     5'h08
`define MSWP_LAT_NS        20
`define MSWP_CLK_NS        25

`endif

/* hw/mswp_pkg.sv */
// types of the multisegment waveform player
// assumes the defs header sits beside it
`include "mswp_defs.svh"
package mswp_pkg;
   typedef enum logic [1:0] {MSWP_CLK_INT, MSWP_CLK_EXT_LOW,
      MSWP_CLK_EXT_HIGH} mswp_clk_src_t;
   typedef enum logic [1:0] {MSWP_TRIG_AUTO, MSWP_TRIG_SINGLE,
      MSWP_TRIG_GATED} mswp_trig_mode_t;
   typedef enum logic [1:0] {MSWP_IDLE, MSWP_ARMED, MSWP_PLAY} mswp_state_t;
endpackage : mswp_pkg

/* dv/mswp_sink.sv */
// far side model: sample memory and external clock source
// assumes the player reads memory combinationally at mem_addr_i
`timescale 1ns/1ps
module mswp_sink
(
   input wire logic clock_i,
   input wire logic [24:0] mem_addr_i,
   output logic [31:0] mem_sample_o,
   output logic ext_clock_o
);
   // memory word tagged by its address so stale reads show
   assign mem_sample_o = {7'h2d, mem_addr_i};
   // free running external clock kept at 20 MHz
   initial
   begin
      ext_clock_o = 1'b0;
      forever #25 ext_clock_o = ~ext_clock_o;
   end
endmodule : mswp_sink

/* dv/mswp_player_tb.sv */
// bench for the multisegment waveform player
// assumes the package, player and sink model are compiled first
`timescale 1ns/1ps
`include "mswp_defs.svh"
module mswp_player_tb
   import mswp_pkg::*;
;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic enable_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic write_i = 1'b0;
   logic read_i = 1'b0;
   logic [31:0] rdata_o, mem_sample_i, sample_o;
   logic ext_clock_pin_i, sample_valid_o, sample_clock_o;
   logic [24:0] mem_addr_o;
   logic [3:0] marker_o;
   logic [1:0] clock_source_o;
   logic [7:0] segment_rate_o;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   mswp_player u_dut (.clock_i, .reset_i, .enable_i, .addr_i, .wdata_i,
      .write_i, .read_i, .rdata_o, .mem_sample_i, .ext_clock_pin_i,
      .mem_addr_o, .sample_o, .marker_o, .sample_valid_o,
      .sample_clock_o, .clock_source_o, .segment_rate_o);
   mswp_sink u_sink (.clock_i, .mem_addr_i(mem_addr_o),
      .mem_sample_o(mem_sample_i), .ext_clock_o(ext_clock_pin_i));
   // 40 MHz clock
   always #12.5 clock_i = ~clock_i;
   // hang guard
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      if (miscompares == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // one write cycle
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      write_i <= 1'b1;
      @(posedge clock_i);
      write_i <= 1'b0;
   endtask : wr
   // read cycle, data taken in the cycle after the strobe
   task automatic rchk(input logic [3:0] a, input logic [31:0] e,
      input string n);
      @(posedge clock_i);
      addr_i <= a;
      read_i <= 1'b1;
      @(posedge clock_i);
      read_i <= 1'b0;
      #1 chk(n, e, rdata_o);
   endtask : rchk
   task automatic t_reset;
      rchk(`MSWP_REG_RESOL, 32'h10, "resolution");
      chk("clock source", 32'h0, 32'(clock_source_o));
   endtask : t_reset
   // every clock source code reaches the output
   task automatic t_clksrc;
      for (int i = 2; i >= 0; i--)
      begin
         wr(`MSWP_REG_CLKSRC, 32'(i));
         @(posedge clock_i);
         #1 chk("clock source", 32'(i), 32'(clock_source_o));
      end
   endtask : t_clksrc
   // thirty one adds, then arm and trigger
   task automatic t_play;
      int n;
      for (int i = 0; i < 31; i++)
         wr(`MSWP_REG_SEGADD, 32'h20000);
      rchk(`MSWP_REG_STATUS, 32'h5e, "status after adds");
      wr(`MSWP_REG_TRIGMODE, 32'(MSWP_TRIG_SINGLE));
      wr(`MSWP_REG_CLKRATE, 32'h10);
      wr(`MSWP_REG_CTRL, 32'h1);
      wr(`MSWP_REG_CTRL, 32'h2);
      #1 n = 0;
      while (sample_valid_o !== 1'b1 && n < 100)
      begin
         @(posedge clock_i);
         #1 n++;
      end
      chk("valid after trigger", 32'h1, 32'(sample_valid_o));
   endtask : t_play
   // index switching and the out of range case
   task automatic t_segsel;
      wr(`MSWP_REG_SEGSEL, 32'h1d);
      rchk(`MSWP_REG_SEGSEL, 32'h1d, "segment index");
      chk("sample segment", 32'h1d, 32'(sample_o[24:17]));
      chk("memory segment", 32'h1d, 32'(mem_addr_o[24:17]));
      chk("marker", 32'h0, 32'(marker_o));
      chk("segment rate", 32'h0, 32'(segment_rate_o));
      chk("sample clock", 32'h1, 32'(sample_clock_o));
      wr(`MSWP_REG_SEGSEL, 32'h1e);
      rchk(`MSWP_REG_SEGSEL, 32'h1d, "segment index");
   endtask : t_segsel
   // settings locked while playing stay as they were
   task automatic t_locked;
      wr(`MSWP_REG_TRIGMODE, 32'(MSWP_TRIG_GATED));
      rchk(`MSWP_REG_TRIGMODE, 32'(MSWP_TRIG_SINGLE), "trig");
      wr(`MSWP_REG_RESOL, 32'h8);
      rchk(`MSWP_REG_RESOL, 32'h10, "resolution");
      wr(`MSWP_REG_CLKRATE, 32'h20);
      rchk(`MSWP_REG_CLKRATE, 32'h10, "clock rate");
      wr(`MSWP_REG_MARKDLY, 32'h5);
      rchk(`MSWP_REG_MARKDLY, 32'h0, "marker delay");
      wr(`MSWP_REG_MARKLIST, 32'h9);
      rchk(`MSWP_REG_MARKLIST, 32'h0, "marker list");
      rchk(`MSWP_REG_STATUS, 32'h3de, "reject flags");
   endtask : t_locked
   // a low clock enable holds the clock source setting
   task automatic t_freeze;
      @(posedge clock_i);
      enable_i <= 1'b0;
      wr(`MSWP_REG_CLKSRC, 32'h1);
      enable_i <= 1'b1;
      @(posedge clock_i);
      #1 chk("clock source frozen", 32'h0, 32'(clock_source_o));
   endtask : t_freeze
   initial
   begin
      repeat (3) @(posedge clock_i);
      reset_i <= 1'b0;
      t_reset();
      t_clksrc();
      t_play();
      t_segsel();
      t_locked();
      t_freeze();
      tally_and_finish();
   end
endmodule : mswp_player_tb
